//--- rtl/ras_pkg.sv
package ras_pkg;
   // Widths
   localparam int PTR_W = 5;
   localparam int PC_W = 21;
   localparam int DEPTH = 32;
   localparam int WB_DW = 32;
   localparam int WB_AW = 8;

   // Pointer limits
   localparam logic [4:0] PTR_EMPTY = 5'h00;
   localparam logic [4:0] PTR_MAX = 5'h1F;

   // Return address step taken on a call and on the overflowing push
   localparam logic [20:0] PC_STEP = 21'h000002;

   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_TOS_LOW = 8'h04;
   localparam logic [7:0] OFS_TOS_HIGH = 8'h08;
   localparam logic [7:0] OFS_TOS_UPPER = 8'h0C;
   localparam logic [7:0] OFS_CONFIG = 8'h10;

   // Register selector codes
   localparam logic [2:0] SEL_NONE = 3'h0;
   localparam logic [2:0] SEL_STATUS = 3'h1;
   localparam logic [2:0] SEL_TOS_LOW = 3'h2;
   localparam logic [2:0] SEL_TOS_HIGH = 3'h3;
   localparam logic [2:0] SEL_TOS_UPPER = 3'h4;
   localparam logic [2:0] SEL_CONFIG = 3'h5;

   // Status register fields
   localparam int BIT_FULL = 7;
   localparam int BIT_UNF = 6;
   localparam int PTR_MSB = 4;
   localparam int PTR_LSB = 0;

   // Config register fields
   localparam int BIT_OVR_EN = 0;

   // Values after reset
   localparam logic RST_OVR_EN = 1'b1;
   localparam logic [4:0] RST_PTR = 5'h00;
endpackage : ras_pkg

//--- rtl/ras_top.sv
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
// Notes on behaviour
// - Stack pointer is five bits, values 0 through 31.
// - Push increments pointer before writing; pop decrements after reading.
// - Any reset sets the stack pointer to zero.
// - Software reads and writes the pointer through the status register.
// - Full flag sets when 31 pushes happen without a pop.
// - Full flag clears only by software or power-on reset.
// - Overflow reset enabled: 31st push stores PC plus 2, sets full, resets.
// - After overflow reset full stays set and pointer is forced to zero.
// - Overflow reset disabled: 31st push sets full, pointer advances to 31.
// - Overflow reset disabled: later pushes keep entry and pointer at 31.
// - Pop on empty stack returns zero, sets underflow, pointer stays zero.
// - Underflow flag stays set until software clear or power-on reset.
// - Underflow return of zero is no reset; other state is untouched.
// - Top entry readable and writable as upper, high and low bytes.
// - Push instruction increments pointer, loads current PC into new top.
// - Pop instruction decrements pointer; previous entry becomes top.
// - Status: full bit 7, underflow bit 6, bit 5 zero, pointer bits 4..0.
module ras_top (
   // Clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Core call and return
   input wire logic call_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [20:0] pc_i,
   output logic [20:0] ret_addr_o,
   output logic ret_valid_o,
   output logic dev_reset_o,
   // Status
   output logic [4:0] pointer_bits_o,
   output logic stack_full_flag_o,
   output logic stack_underflow_flag_o
);

   function automatic logic [2:0] reg_of(input logic [7:0] adr);
      logic [2:0] s;
      s = ras_pkg::SEL_NONE;
      if (adr == ras_pkg::OFS_STATUS) s = ras_pkg::SEL_STATUS;
      if (adr == ras_pkg::OFS_TOS_LOW) s = ras_pkg::SEL_TOS_LOW;
      if (adr == ras_pkg::OFS_TOS_HIGH) s = ras_pkg::SEL_TOS_HIGH;
      if (adr == ras_pkg::OFS_TOS_UPPER) s = ras_pkg::SEL_TOS_UPPER;
      if (adr == ras_pkg::OFS_CONFIG) s = ras_pkg::SEL_CONFIG;
      return s;
   endfunction : reg_of

   // Entry 0 is never written: an empty stack reads as zero
   logic [20:0] stack_mem [0:ras_pkg::DEPTH-1];

   logic [4:0] stack_pointer_reg_ff, nxt_stack_pointer_reg;
   logic stack_full_flag_ff, nxt_stack_full_flag;
   logic stack_underflow_flag_ff, nxt_stack_underflow_flag;
   logic overflow_reset_enable_ff, nxt_overflow_reset_enable;
   logic ack_ff, nxt_ack;
   logic [31:0] dat_ff, nxt_dat;
   logic [20:0] ret_ff, nxt_ret;
   logic ret_vld_ff, nxt_ret_vld;
   logic devrst_ff, nxt_devrst;
   logic mem_we;
   logic [4:0] mem_idx;
   logic [20:0] mem_wdata;
   logic [20:0] top_of_stack;
   logic [20:0] push_val;
   logic [4:0] ptr_inc;
   logic [4:0] ptr_dec;
   logic [2:0] rsel;
   logic bus_req;
   logic bus_wr;
   logic core_push;

   assign bus_req = wb_cyc_i & wb_stb_i;
   // Write lands on the edge where ack is seen by the master
   assign bus_wr = bus_req & wb_we_i & ack_ff & wb_sel_i[0];
   assign rsel = reg_of(wb_adr_i);
   assign core_push = call_i | push_i;
   assign push_val = call_i ? pc_i + ras_pkg::PC_STEP : pc_i;
   assign ptr_inc = stack_pointer_reg_ff + 5'h01;
   assign ptr_dec = stack_pointer_reg_ff - 5'h01;
   assign top_of_stack = (stack_pointer_reg_ff == ras_pkg::PTR_EMPTY) ? 21'h000000 :
                         stack_mem[stack_pointer_reg_ff];

   always_comb begin
      nxt_stack_pointer_reg = stack_pointer_reg_ff;
      nxt_stack_full_flag = stack_full_flag_ff;
      nxt_stack_underflow_flag = stack_underflow_flag_ff;
      nxt_overflow_reset_enable = overflow_reset_enable_ff;
      nxt_ret = ret_ff;
      nxt_ret_vld = 1'b0;
      nxt_devrst = 1'b0;
      mem_we = 1'b0;
      mem_idx = stack_pointer_reg_ff;
      mem_wdata = top_of_stack;
      // Software side
      if (bus_wr) begin
         unique case (rsel)
            ras_pkg::SEL_STATUS: begin
               nxt_stack_pointer_reg = wb_dat_i[ras_pkg::PTR_MSB:ras_pkg::PTR_LSB];
               if (!wb_dat_i[ras_pkg::BIT_FULL]) nxt_stack_full_flag = 1'b0;
               if (!wb_dat_i[ras_pkg::BIT_UNF]) nxt_stack_underflow_flag = 1'b0;
            end
            ras_pkg::SEL_TOS_LOW: begin
               mem_we = (stack_pointer_reg_ff != ras_pkg::PTR_EMPTY);
               mem_wdata[7:0] = wb_dat_i[7:0];
            end
            ras_pkg::SEL_TOS_HIGH: begin
               mem_we = (stack_pointer_reg_ff != ras_pkg::PTR_EMPTY);
               mem_wdata[15:8] = wb_dat_i[7:0];
            end
            ras_pkg::SEL_TOS_UPPER: begin
               mem_we = (stack_pointer_reg_ff != ras_pkg::PTR_EMPTY);
               mem_wdata[20:16] = wb_dat_i[4:0];
            end
            ras_pkg::SEL_CONFIG: begin
               nxt_overflow_reset_enable = wb_dat_i[ras_pkg::BIT_OVR_EN];
            end
            default: begin
            end
         endcase
      end
      // Core side overrides software in the same cycle, so a set beats a clear
      if (core_push) begin
         if (stack_pointer_reg_ff == ras_pkg::PTR_MAX) begin
            mem_we = 1'b0;
            nxt_stack_full_flag = 1'b1;
            if (overflow_reset_enable_ff) begin
               nxt_stack_pointer_reg = ras_pkg::PTR_EMPTY;
               nxt_devrst = 1'b1;
            end else begin
               nxt_stack_pointer_reg = ras_pkg::PTR_MAX;
            end
         end else begin
            mem_we = 1'b1;
            mem_idx = ptr_inc;
            mem_wdata = push_val;
            nxt_stack_pointer_reg = ptr_inc;
            if (ptr_inc == ras_pkg::PTR_MAX) begin
               nxt_stack_full_flag = 1'b1;
               if (overflow_reset_enable_ff) begin
                  mem_wdata = pc_i + ras_pkg::PC_STEP;
                  nxt_stack_pointer_reg = ras_pkg::PTR_EMPTY;
                  nxt_devrst = 1'b1;
               end
            end
         end
      end else if (pop_i) begin
         nxt_ret_vld = 1'b1;
         if (stack_pointer_reg_ff == ras_pkg::PTR_EMPTY) begin
            nxt_ret = 21'h000000;
            nxt_stack_underflow_flag = 1'b1;
         end else begin
            nxt_ret = top_of_stack;
            nxt_stack_pointer_reg = ptr_dec;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         stack_mem[mem_idx] <= mem_wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i | por_i) begin
         stack_pointer_reg_ff <= ras_pkg::RST_PTR;
         overflow_reset_enable_ff <= ras_pkg::RST_OVR_EN;
         ret_ff <= 21'h000000;
         ret_vld_ff <= 1'b0;
         devrst_ff <= 1'b0;
      end else begin
         stack_pointer_reg_ff <= nxt_stack_pointer_reg;
         overflow_reset_enable_ff <= nxt_overflow_reset_enable;
         ret_ff <= nxt_ret;
         ret_vld_ff <= nxt_ret_vld;
         devrst_ff <= nxt_devrst;
      end
   end

   // Flags survive every reset except power-on
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         stack_full_flag_ff <= 1'b0;
         stack_underflow_flag_ff <= 1'b0;
      end else begin
         stack_full_flag_ff <= nxt_stack_full_flag;
         stack_underflow_flag_ff <= nxt_stack_underflow_flag;
      end
   end

   // Bus answer
   always_comb begin
      nxt_ack = bus_req & ~ack_ff;
      nxt_dat = 32'h00000000;
      unique case (rsel)
         ras_pkg::SEL_STATUS: begin
            nxt_dat[ras_pkg::BIT_FULL] = stack_full_flag_ff;
            nxt_dat[ras_pkg::BIT_UNF] = stack_underflow_flag_ff;
            nxt_dat[ras_pkg::PTR_MSB:ras_pkg::PTR_LSB] = stack_pointer_reg_ff;
         end
         ras_pkg::SEL_TOS_LOW: nxt_dat[7:0] = top_of_stack[7:0];
         ras_pkg::SEL_TOS_HIGH: nxt_dat[7:0] = top_of_stack[15:8];
         ras_pkg::SEL_TOS_UPPER: nxt_dat[4:0] = top_of_stack[20:16];
         ras_pkg::SEL_CONFIG: nxt_dat[ras_pkg::BIT_OVR_EN] = overflow_reset_enable_ff;
         default: nxt_dat = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i | por_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end else begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign ret_addr_o = ret_ff;
   assign ret_valid_o = ret_vld_ff;
   assign dev_reset_o = devrst_ff;
   assign pointer_bits_o = stack_pointer_reg_ff;
   assign stack_full_flag_o = stack_full_flag_ff;
   assign stack_underflow_flag_o = stack_underflow_flag_ff;

endmodule : ras_top

//--- verification/ras_chk.sv
`timescale 1ns/1ns
module ras_chk (
   // Clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   // Bus
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Core and status
   input wire logic call_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [20:0] ret_addr_o,
   input wire logic ret_valid_o,
   input wire logic dev_reset_o,
   input wire logic [4:0] pointer_bits_o,
   input wire logic stack_full_flag_o,
   input wire logic stack_underflow_flag_o
);
   wire psh = call_i | push_i;
   wire pop1 = pop_i & ~psh;
   wire st_wr = wb_ack_o & wb_we_i & (wb_adr_i == 8'h00) & wb_sel_i[0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || por_i);
   property p_push;
      psh && pointer_bits_o < 5'h1E |=> pointer_bits_o == $past(pointer_bits_o) + 5'h01;
   endproperty
   a_push: assert property (p_push)
      else $error("pointer did not step up on push");
   property p_pop;
      pop1 && pointer_bits_o != 5'h00 |=> ret_valid_o && pointer_bits_o == $past(pointer_bits_o) - 5'h01;
   endproperty
   a_pop: assert property (p_pop)
      else $error("pointer did not step down on pop");
   property p_unf;
      pop1 && pointer_bits_o == 5'h00 |=> ret_valid_o && ret_addr_o == 21'h000000
         && stack_underflow_flag_o && pointer_bits_o == 5'h00;
   endproperty
   a_unf: assert property (p_unf)
      else $error("empty pop handled wrongly");
   property p_full;
      psh && pointer_bits_o == 5'h1E |=> stack_full_flag_o;
   endproperty
   a_full: assert property (p_full)
      else $error("full flag not set");
   // Plain reset must not clear flags, so only power-on disables these
   property p_full_keep;
      disable iff (por_i) stack_full_flag_o && !(st_wr && !wb_dat_i[7]) |=> stack_full_flag_o;
   endproperty
   a_full_keep: assert property (p_full_keep)
      else $error("full flag lost");
   property p_unf_keep;
      disable iff (por_i)
         stack_underflow_flag_o && !(st_wr && !wb_dat_i[6]) |=> stack_underflow_flag_o;
   endproperty
   a_unf_keep: assert property (p_unf_keep)
      else $error("underflow flag lost");
   property p_rst;
      disable iff (1'h0) rst_i || por_i |=> pointer_bits_o == 5'h00 && !dev_reset_o;
   endproperty
   a_rst: assert property (p_rst)
      else $error("pointer not zero after reset");
   property p_ovf;
      dev_reset_o |-> stack_full_flag_o && pointer_bits_o == 5'h00;
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow left wrong state");
   property p_stat;
      wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> !wb_dat_o[5] && wb_dat_o[31:8] == 24'h000000;
   endproperty
   a_stat: assert property (p_stat)
      else $error("status spare bits not zero");
endmodule : ras_chk
bind ras_top ras_chk u_chk (.clk_i, .rst_i, .por_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .call_i, .push_i, .pop_i, .ret_addr_o, .ret_valid_o, .dev_reset_o,
   .pointer_bits_o, .stack_full_flag_o, .stack_underflow_flag_o);

//--- verification/ras_core_model.sv
`timescale 1ns/1ns
module ras_core_model (
   // Command
   input wire logic clk_i,
   input wire logic [1:0] op_i,
   input wire logic [20:0] pc_req_i,
   // Core side
   output logic call_o,
   output logic push_o,
   output logic pop_o,
   output logic [20:0] pc_o
);
   logic [20:0] last_ff = 21'h000000;
   always_ff @(posedge clk_i) begin
      if (op_i != 2'h0) last_ff <= pc_req_i;
   end
   // Idle PC is not held; inverse hides reliance on a stale value
   assign pc_o = (op_i != 2'h0) ? pc_req_i : ~last_ff;
   assign call_o = op_i == 2'h1;
   assign push_o = op_i == 2'h2;
   assign pop_o = op_i == 2'h3;
endmodule : ras_core_model

//--- verification/ras_top_bench.sv
`timescale 1ns/1ns
module ras_top_bench;
   logic clk_i = 1'h0, rst_i = 1'h1, por_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [1:0] op = 2'h0;
   logic [20:0] pcq = 21'h0, pc_w, ret;
   logic call_w, push_w, pop_w, rv, dr, ful, unf;
   logic [4:0] ptr;
   int err_total = 0, tests_run = 0;
   always #4 clk_i = ~clk_i;
   ras_top uut (.clk_i, .rst_i, .por_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .call_i(call_w), .push_i(push_w), .pop_i(pop_w), .pc_i(pc_w), .ret_addr_o(ret),
      .ret_valid_o(rv), .dev_reset_o(dr), .pointer_bits_o(ptr), .stack_full_flag_o(ful),
      .stack_underflow_flag_o(unf));
   ras_core_model core (.clk_i, .op_i(op), .pc_req_i(pcq), .call_o(call_w), .push_o(push_w),
      .pop_o(pop_w), .pc_o(pc_w));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'h1 && ++n < 20);
      if (ack !== 1'h1) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, ack, 1'h1);
      end
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk_i);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic core_op(input logic [1:0] k, input logic [20:0] p);
      op <= k;
      pcq <= p;
      @(posedge clk_i);
      op <= 2'h0;
      @(posedge clk_i);
   endtask : core_op
   task automatic t_regs;
      rd(8'h00, 32'h00);
      bus(1'h1, 8'h00, 32'h05);
      rd(8'h00, 32'h05);
      rd(8'h14, 32'h00);
      $display("test regs done");
   endtask : t_regs
   task automatic t_stack;
      bus(1'h1, 8'h00, 32'h00);
      core_op(2'h2, 21'h012345);
      core_op(2'h1, 21'h000100);
      rd(8'h00, 32'h02);
      rd(8'h04, 32'h02);
      rd(8'h08, 32'h01);
      bus(1'h1, 8'h04, 32'hAA);
      core_op(2'h3, 21'h0);
      chk(ret, 32'h1AA);
      rd(8'h0C, 32'h01);
      core_op(2'h3, 21'h0);
      chk(ret, 32'h12345);
      core_op(2'h3, 21'h0);
      chk({rv, ret}, 32'h200000);
      rd(8'h00, 32'h40);
      rd(8'h10, 32'h01);
      rst_i <= 1'h1;
      @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      rd(8'h00, 32'h40);
      bus(1'h1, 8'h00, 32'h00);
      rd(8'h00, 32'h00);
      $display("test stack done");
   endtask : t_stack
   task automatic t_ovf;
      bus(1'h1, 8'h10, 32'h00);
      bus(1'h1, 8'h00, 32'h1D);
      core_op(2'h2, 21'h0ABCDE);
      core_op(2'h2, 21'h0ABCE0);
      rd(8'h00, 32'h9F);
      core_op(2'h2, 21'h111111);
      rd(8'h00, 32'h9F);
      rd(8'h04, 32'hE0);
      bus(1'h1, 8'h00, 32'h00);
      bus(1'h1, 8'h10, 32'h01);
      bus(1'h1, 8'h00, 32'h1E);
      core_op(2'h2, 21'h054320);
      chk(dr, 32'h1);
      rd(8'h00, 32'h80);
      bus(1'h1, 8'h00, 32'h9F);
      rd(8'h04, 32'h22);
      rd(8'h0C, 32'h05);
      por_i <= 1'h1;
      @(posedge clk_i);
      por_i <= 1'h0;
      @(posedge clk_i);
      rd(8'h00, 32'h00);
      $display("test overflow done");
   endtask : t_ovf
   task automatic close_out;
      $display("compares %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   initial begin
      repeat (3000) @(posedge clk_i);
      err_total++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      por_i <= 1'h0;
      @(posedge clk_i);
      t_regs();
      t_stack();
      t_ovf();
      close_out();
   end
endmodule : ras_top_bench
